// *** ctp_monitor.sv ***
// port checker of the cyclic time pulse generator
`timescale 1ns/1ns
module ctp_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // second strobe and clock status
    input wire logic sec_tick,
    input wire logic time_valid,
    input wire logic time_locked,
    input wire logic steering_active,
    input wire logic loss_holdoff_timer,
    input wire logic simulation_mode,
    input wire logic acquisition_timer,
    input wire logic was_locked,
    input wire logic set_after_reset,
    // pulse output
    input wire logic pulse_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // helper logic
    logic low_q;
    logic [2:0] minq_q;
    logic seen_q;
    logic [7:0] qin_q;
    logic [1:0] still_q;
    wire ctl_wr = reg_write && reg_addr == ctp_pkg::CTRL_OFFSET;
    wire st_rd = reg_read && reg_addr == ctp_pkg::STATUS_OFFSET;
    wire active = pulse_out ^ low_q;
    wire [7:0] qin = {time_valid, time_locked, steering_active, loss_holdoff_timer,
                      simulation_mode, acquisition_timer, was_locked, set_after_reset};
    wire calm = still_q == 2'h3 && qin == qin_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            low_q <= 1'b0;
            minq_q <= 3'h0;
            seen_q <= 1'b0;
            qin_q <= 8'h00;
            still_q <= 2'h0;
        end else begin
            qin_q <= qin;
            if (ctl_wr) begin
                low_q <= reg_wdata[5];
                minq_q <= reg_wdata[8:6];
            end
            if (ctl_wr && reg_wdata[8:6] != minq_q) begin
                seen_q <= 1'b0;
            end else if ($past(st_rd) && reg_rdata[3]) begin
                seen_q <= 1'b1;
            end
            if (ctl_wr || qin != qin_q) still_q <= 2'h0;
            else if (still_q != 2'h3) still_q <= still_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // properties
    property p_rdata_idle;
        !reg_read |=> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");

    property p_start_tick;
        $rose(active) && calm |-> $past(sec_tick, 2);
    endproperty
    a_start_tick: assert property (p_start_tick) else $error("pulse started without a second strobe");

    property p_rank_range;
        st_rd |=> reg_rdata[2:0] != 3'h7;
    endproperty
    a_rank_range: assert property (p_rank_range) else $error("quality rank out of range");

    property p_rank_steered;
        st_rd && calm && time_valid && time_locked && steering_active && !loss_holdoff_timer
            |=> reg_rdata[2:0] == 3'h6;
    endproperty
    a_rank_steered: assert property (p_rank_steered) else $error("steered lock not ranked top");

    property p_rank_invalid;
        st_rd && calm && !time_valid |=> reg_rdata[2:0] == 3'h0;
    endproperty
    a_rank_invalid: assert property (p_rank_invalid) else $error("invalid time not ranked lowest");

    property p_rank_acq;
        st_rd && calm && time_valid && !time_locked && !simulation_mode && acquisition_timer
            |=> reg_rdata[2:0] == 3'h3;
    endproperty
    a_rank_acq: assert property (p_rank_acq) else $error("acquisition not ranked three");

    property p_reached_sticky;
        st_rd && seen_q |=> reg_rdata[3];
    endproperty
    a_reached_sticky: assert property (p_reached_sticky) else $error("reached flag dropped");

    property p_emit_good;
        st_rd && calm ##1 reg_rdata[2:0] >= minq_q |-> reg_rdata[4];
    endproperty
    a_emit_good: assert property (p_emit_good) else $error("emit off at sufficient quality");

    c_pulse: cover property ($rose(active));
    c_status: cover property (st_rd && calm);
    c_low: cover property (ctl_wr && reg_wdata[5]);
endmodule

// *** ctp_pkg.sv ***
// constants, register map and types of the cyclic time pulse generator
package ctp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLOCK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
    localparam int SEC_PER_MIN = 60;
    localparam int SEC_PER_HOUR = 3600;
    localparam logic [16:0] HALF_DAY_S = 17'h0a8c0;
    localparam logic [15:0] WIDTH_MIN_MS = 16'h000a;
    localparam logic [15:0] WIDTH_MIN_S = 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CYCLE_OFFSET = 8'h04;
    localparam logic [7:0] WIDTH_OFFSET = 8'h08;
    localparam logic [7:0] TIMEOUT_OFFSET = 8'h0c;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // control fields
    localparam int CTRL_BASE_POS = 0;
    localparam int CTRL_CLASS_POS = 2;
    localparam int CTRL_UNIT_MS_POS = 4;
    localparam int CTRL_LOW_POS = 5;
    localparam int CTRL_MINQ_POS = 6;

    // status fields
    localparam int STAT_QUAL_POS = 0;
    localparam int STAT_REACHED_POS = 3;
    localparam int STAT_EMIT_POS = 4;
    localparam int STAT_ACTIVE_POS = 5;
    localparam int STAT_VALID_POS = 6;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [8:0] CTRL_RESET = 9'h000;
    localparam logic [4:0] CYCLE_RESET = 5'h01;
    localparam logic [15:0] WIDTH_RESET = 16'h0064;
    localparam logic [10:0] TIMEOUT_RESET = 11'h000;

    ////////////////////////////////////////////////////////////////////////
    // enumerations
    typedef enum logic [1:0] {
        BASE_LOCAL = 2'h0,
        BASE_STANDARD = 2'h1,
        BASE_UTC = 2'h2
    } ctp_base_type;

    typedef enum logic [1:0] {
        CLASS_SECONDS = 2'h0,
        CLASS_MINUTES = 2'h1,
        CLASS_HOURS = 2'h2
    } ctp_class_type;

    typedef enum logic [2:0] {
        time_invalid = 3'h0,
        free_run_after_reset = 3'h1,
        free_run_after_loss = 3'h2,
        free_run_acquiring = 3'h3,
        locked_simulated = 3'h4,
        locked_holdoff = 3'h5,
        locked_steered = 3'h6
    } ctp_quality_type;

endpackage

// *** ctp_pulse_gen.sv ***
// cyclic time pulse generator top level
// Function
// - pulse timing follows local, standard or UTC time as configured
// - second cycles 1,2,3,4,5,6,10,12,15,20,30 s supported
// - minute cycles 1,2,3,4,5,6,10,12,15,20,30 min supported
// - hour cycles 1,2,3,4,6,8,12,24 h supported
// - millisecond widths from 10 ms to cycle minus 10 ms, so at most 990 ms
// - second widths from 1 s to cycle minus 1 s up to 12 h, else 65535
// - millisecond width unit allowed only with a one second cycle
// - output polarity selectable high or low active
// - pulses emitted while quality is at or above the configured minimum
// - no pulses until the minimum quality has been reached once
// - after a drop, pulses continue until the time-out expires
// - quality ranks from time_invalid up to locked_steered
// - locked states chosen from steering, hold-off timer and simulation
// - free-run states chosen from acquisition, earlier lock and reset
`timescale 1ns/1ns
module ctp_pulse_gen #(
    parameter int CYCLES_PER_MS = ctp_pkg::CYCLES_PER_MS,
    parameter int WIDTH_BITS = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // second strobe and time of the new second
    input wire logic sec_tick,
    input wire logic [5:0] local_sec,
    input wire logic [5:0] local_min,
    input wire logic [4:0] local_hour,
    input wire logic [5:0] std_sec,
    input wire logic [5:0] std_min,
    input wire logic [4:0] std_hour,
    input wire logic [5:0] utc_sec,
    input wire logic [5:0] utc_min,
    input wire logic [4:0] utc_hour,
    // clock status
    input wire logic time_valid,
    input wire logic time_locked,
    input wire logic steering_active,
    input wire logic loss_holdoff_timer,
    input wire logic simulation_mode,
    input wire logic acquisition_timer,
    input wire logic was_locked,
    input wire logic set_after_reset,
    // pulse output
    output logic pulse_out
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic cycle_ok(input logic [1:0] cls, input logic [4:0] n);
        logic ok;
        ok = 1'b0;
        if (cls == ctp_pkg::CLASS_HOURS) begin
            case (n)
                5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h18: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end else if (cls == ctp_pkg::CLASS_SECONDS || cls == ctp_pkg::CLASS_MINUTES) begin
            case (n)
                5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0a, 5'h0c, 5'h0f, 5'h14, 5'h1e: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    function automatic logic [16:0] cycle_seconds(input logic [1:0] cls, input logic [4:0] n);
        logic [16:0] s;
        s = {12'h000, n};
        if (cls == ctp_pkg::CLASS_MINUTES) begin
            s = 17'(n * ctp_pkg::SEC_PER_MIN);
        end else if (cls == ctp_pkg::CLASS_HOURS) begin
            s = 17'(n * ctp_pkg::SEC_PER_HOUR);
        end
        return s;
    endfunction

    function automatic logic multiple_of(input logic [5:0] value, input logic [4:0] n);
        return (n != 5'h00) && ((value % {1'b0, n}) == 6'h00);
    endfunction

    function automatic logic [2:0] rank_status(input logic valid, input logic locked, input logic steer,
                                               input logic holdoff, input logic sim, input logic acq,
                                               input logic lost, input logic set);
        logic [2:0] q;
        q = ctp_pkg::time_invalid;
        if (!valid) begin
            q = ctp_pkg::time_invalid;
        end else if (locked && holdoff) begin
            q = ctp_pkg::locked_holdoff;
        end else if (locked && (steer || !sim)) begin
            q = ctp_pkg::locked_steered;
        end else if (sim) begin
            q = ctp_pkg::locked_simulated;
        end else if (acq) begin
            q = ctp_pkg::free_run_acquiring;
        end else if (lost) begin
            q = ctp_pkg::free_run_after_loss;
        end else if (set) begin
            q = ctp_pkg::free_run_after_reset;
        end
        return q;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [8:0] ctrl_q;
    logic [4:0] cycle_q;
    logic [WIDTH_BITS-1:0] width_q;
    logic [10:0] timeout_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    wire sel_ctrl = (reg_addr == ctp_pkg::CTRL_OFFSET);
    wire sel_cycle = (reg_addr == ctp_pkg::CYCLE_OFFSET);
    wire sel_width = (reg_addr == ctp_pkg::WIDTH_OFFSET);
    wire sel_timeout = (reg_addr == ctp_pkg::TIMEOUT_OFFSET);
    wire sel_status = (reg_addr == ctp_pkg::STATUS_OFFSET);

    wire [1:0] base_sel = ctrl_q[ctp_pkg::CTRL_BASE_POS +: 2];
    wire [1:0] cycle_class = ctrl_q[ctp_pkg::CTRL_CLASS_POS +: 2];
    wire unit_ms = ctrl_q[ctp_pkg::CTRL_UNIT_MS_POS];
    wire low_active = ctrl_q[ctp_pkg::CTRL_LOW_POS];
    wire [2:0] min_quality = ctrl_q[ctp_pkg::CTRL_MINQ_POS +: 3];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= ctp_pkg::CTRL_RESET;
            cycle_q <= ctp_pkg::CYCLE_RESET;
            width_q <= WIDTH_BITS'(ctp_pkg::WIDTH_RESET);
            timeout_q <= ctp_pkg::TIMEOUT_RESET;
        end else if (reg_write) begin
            if (sel_ctrl) begin
                ctrl_q <= reg_wdata[8:0];
            end
            if (sel_cycle) begin
                cycle_q <= reg_wdata[4:0];
            end
            if (sel_width) begin
                width_q <= reg_wdata[WIDTH_BITS-1:0];
            end
            if (sel_timeout) begin
                timeout_q <= reg_wdata[10:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration check

    wire [16:0] cyc_s = cycle_seconds(cycle_class, cycle_q);
    wire [WIDTH_BITS-1:0] ms_limit = WIDTH_BITS'(ctp_pkg::MS_PER_S) - ctp_pkg::WIDTH_MIN_MS;
    wire [16:0] width_ext = 17'(width_q);
    wire cls_seconds = (cycle_class == ctp_pkg::CLASS_SECONDS);
    wire ms_allowed = cls_seconds && (cycle_q == 5'h01);
    wire ms_width_ok = (width_q >= ctp_pkg::WIDTH_MIN_MS) && (width_q <= ms_limit);
    wire s_upper_ok = (cyc_s > ctp_pkg::HALF_DAY_S) || (width_ext < cyc_s);
    wire s_width_ok = (width_q >= ctp_pkg::WIDTH_MIN_S) && s_upper_ok;
    wire width_ok = unit_ms ? (ms_allowed && ms_width_ok) : s_width_ok;
    wire config_valid = cycle_ok(cycle_class, cycle_q) && width_ok;

    ////////////////////////////////////////////////////////////////////////
    // time base selection and boundary

    logic [5:0] cur_sec;
    logic [5:0] cur_min;
    logic [4:0] cur_hour;

    always_comb begin
        case (base_sel)
            ctp_pkg::BASE_STANDARD: begin
                cur_sec = std_sec;
                cur_min = std_min;
                cur_hour = std_hour;
            end
            ctp_pkg::BASE_UTC: begin
                cur_sec = utc_sec;
                cur_min = utc_min;
                cur_hour = utc_hour;
            end
            default: begin
                cur_sec = local_sec;
                cur_min = local_min;
                cur_hour = local_hour;
            end
        endcase
    end

    wire sec_zero = (cur_sec == 6'h00);
    wire min_zero = (cur_min == 6'h00);
    wire hit_sec = multiple_of(cur_sec, cycle_q);
    wire hit_min = sec_zero && multiple_of(cur_min, cycle_q);
    wire hit_hour = sec_zero && min_zero && multiple_of({1'b0, cur_hour}, cycle_q);
    wire hit_class = (cycle_class == ctp_pkg::CLASS_HOURS) ? hit_hour :
                     ((cycle_class == ctp_pkg::CLASS_MINUTES) ? hit_min : hit_sec);
    wire pulse_start = sec_tick && config_valid && hit_class;

    ////////////////////////////////////////////////////////////////////////
    // millisecond prescaler aligned to the second strobe

    localparam int PRE_BITS = $clog2(CYCLES_PER_MS + 1);
    localparam logic [PRE_BITS-1:0] PRE_LAST = PRE_BITS'(CYCLES_PER_MS - 1);

    logic [PRE_BITS-1:0] pre_q;
    wire pre_wrap = (pre_q == PRE_LAST);
    wire ms_tick = pre_wrap && !sec_tick;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_q <= '0;
        end else if (sec_tick || pre_wrap) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse width

    logic pulse_active;
    wire width_step = unit_ms ? ms_tick : sec_tick;

    ctp_width_counter #(
        .WIDTH_BITS(WIDTH_BITS)
    ) u_width (
        .clock(clock),
        .rst(rst),
        .start(pulse_start),
        .step(width_step),
        .width(width_q),
        .active(pulse_active)
    );

    ////////////////////////////////////////////////////////////////////////
    // quality gating

    logic [2:0] quality_q;
    logic reached_q;
    logic holding;

    wire [2:0] quality_d = rank_status(time_valid, time_locked, steering_active, loss_holdoff_timer,
                                       simulation_mode, acquisition_timer, was_locked, set_after_reset);
    wire good = (quality_q >= min_quality);
    // a new minimum has to be reached afresh
    wire [2:0] min_next = reg_wdata[ctp_pkg::CTRL_MINQ_POS +: 3];
    wire min_write = reg_write && sel_ctrl && (min_next != min_quality);
    wire emit = good || (reached_q && holding);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            quality_q <= ctp_pkg::time_invalid;
            reached_q <= 1'b0;
        end else begin
            quality_q <= quality_d;
            reached_q <= min_write ? (quality_q >= min_next) : (reached_q || good);
        end
    end

    ctp_timeout #(
        .MIN_BITS(11),
        .SEC_BITS(17)
    ) u_timeout (
        .clock(clock),
        .rst(rst),
        .good(good),
        .sec_tick(sec_tick),
        .timeout_min(timeout_q),
        .holding(holding)
    );

    ////////////////////////////////////////////////////////////////////////
    // output

    logic out_q;
    wire out_d = (pulse_active && emit && config_valid) ^ low_active;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    assign pulse_out = out_q;

    ////////////////////////////////////////////////////////////////////////
    // read back

    wire [31:0] status_word = {25'h0000000, config_valid, pulse_active, emit, reached_q, quality_q};

    always_comb begin
        rdata_d = 32'h00000000;
        if (reg_read) begin
            if (sel_ctrl) begin
                rdata_d = {23'h000000, ctrl_q};
            end else if (sel_cycle) begin
                rdata_d = {27'h0000000, cycle_q};
            end else if (sel_width) begin
                rdata_d = 32'(width_q);
            end else if (sel_timeout) begin
                rdata_d = {21'h000000, timeout_q};
            end else if (sel_status) begin
                rdata_d = status_word;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule

// *** ctp_pulse_sink.sv ***
// downstream equipment model measuring each timing pulse
`timescale 1ns/1ns
module ctp_pulse_sink (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // pulse line and configured polarity
    input wire logic pulse_out,
    input wire logic low_active,
    // measurements
    output int pulses,
    output int last_len
);
    int run;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pulses <= 0;
            last_len <= 0;
            run <= 0;
        end else if (pulse_out ^ low_active) begin
            run <= run + 1;
        end else if (run > 0) begin
            pulses <= pulses + 1;
            last_len <= run;
            run <= 0;
        end
    end
endmodule

// *** ctp_timeout.sv ***
// bridging time-out after loss of required quality
`timescale 1ns/1ns
module ctp_timeout #(
    parameter int MIN_BITS = 11,
    parameter int SEC_BITS = 17
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // quality
    input wire logic good,
    input wire logic sec_tick,
    input wire logic [MIN_BITS-1:0] timeout_min,
    // state
    output logic holding
);

    logic [SEC_BITS-1:0] count_q;
    logic [SEC_BITS-1:0] count_d;
    logic good_q;
    logic fell;
    logic [SEC_BITS-1:0] load_value;

    assign fell = good_q && !good;
    assign load_value = SEC_BITS'(timeout_min * ctp_pkg::SEC_PER_MIN);
    // bridging starts in the very cycle of the drop, so a running pulse has no gap
    assign holding = (count_q != '0) || (fell && (load_value != '0));

    always_comb begin
        count_d = count_q;
        if (good) begin
            count_d = '0;
        end else if (fell) begin
            count_d = load_value;
        end else if (sec_tick && holding) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= '0;
            good_q <= 1'b0;
        end else begin
            count_q <= count_d;
            good_q <= good;
        end
    end

endmodule

// *** ctp_width_counter.sv ***
// pulse width down-counter
`timescale 1ns/1ns
module ctp_width_counter #(
    parameter int WIDTH_BITS = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic start,
    input wire logic step,
    input wire logic [WIDTH_BITS-1:0] width,
    // state
    output logic active
);

    logic [WIDTH_BITS-1:0] count_q;
    logic [WIDTH_BITS-1:0] count_d;
    logic running;

    assign running = (count_q != '0);
    assign count_d = start ? width : ((step && running) ? count_q - 1'b1 : count_q);
    assign active = running;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule

// *** test_ctp_pulse_gen.sv ***
// self-checking testbench of the cyclic time pulse generator
`timescale 1ns/1ns
module test_ctp_pulse_gen;
    localparam int CMS = 10;
    localparam logic [16:0] NB = 17'h038e7;
    typedef struct {
        logic [8:0] ctrl;
        logic [4:0] cyc;
        logic [15:0] w;
        logic [16:0] t;
        int n;
        int len;
    } ctp_row_type;
    logic clock, rst, reg_write, reg_read, sec_tick, low;
    logic [7:0] reg_addr, qv;
    logic [31:0] reg_wdata, d;
    logic [16:0] t_loc, t_std, t_utc;
    wire [31:0] reg_rdata;
    wire pulse_out;
    int pulses, last_len, n_fail, checked, n0;
    ctp_row_type rows[14] = '{
        '{9'h010, 5'h01, 16'h000a, 17'h0, 1, 100},
        '{9'h010, 5'h01, 16'h03de, 17'h0, 1, 9900},
        '{9'h010, 5'h01, 16'h03df, 17'h0, 0, 0},
        '{9'h010, 5'h01, 16'h0009, 17'h0, 0, 0},
        '{9'h010, 5'h02, 16'h000a, 17'h0, 0, 0},
        '{9'h021, 5'h1e, 16'h001d, 17'h0f000, 1, 580},
        '{9'h002, 5'h1e, 16'h001e, 17'h0f000, 0, 0},
        '{9'h006, 5'h1e, 16'h0002, 17'h003c0, 1, 40},
        '{9'h008, 5'h18, 16'h0003, 17'h0, 1, 60},
        '{9'h008, 5'h08, 16'h0001, 17'h00010, 1, 20},
        '{9'h000, 5'h07, 16'h0001, 17'h0, 0, 0},
        '{9'h008, 5'h05, 16'h0001, 17'h0, 0, 0},
        '{9'h001, 5'h05, 16'h0001, 17'h05000, 1, 20},
        '{9'h004, 5'h05, 16'h0001, 17'h00940, 0, 0}
    };
    logic [7:0] qrow[10] = '{8'h00, 8'h80, 8'h81, 8'h82, 8'h86, 8'h88, 8'hd0, 8'hf0, 8'he8, 8'hc0};
    logic [2:0] qrank[10] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6};
    logic [7:0] raddr[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
    logic [31:0] rval[5] = '{32'h0, 32'h1, 32'h64, 32'h0, 32'h0};

    ctp_pulse_gen #(.CYCLES_PER_MS(CMS)) uut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sec_tick(sec_tick), .local_sec(t_loc[16:11]), .local_min(t_loc[10:5]), .local_hour(t_loc[4:0]),
        .std_sec(t_std[16:11]), .std_min(t_std[10:5]), .std_hour(t_std[4:0]), .utc_sec(t_utc[16:11]),
        .utc_min(t_utc[10:5]), .utc_hour(t_utc[4:0]), .time_valid(qv[7]), .time_locked(qv[6]),
        .steering_active(qv[5]), .loss_holdoff_timer(qv[4]), .simulation_mode(qv[3]),
        .acquisition_timer(qv[2]), .was_locked(qv[1]), .set_after_reset(qv[0]), .pulse_out(pulse_out));
    ctp_pulse_sink sink (.clock(clock), .rst(rst), .pulse_out(pulse_out), .low_active(low),
        .pulses(pulses), .last_len(last_len));

    ////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic tick(input logic [1:0] b, input logic [16:0] t);
        @(posedge clock);
        sec_tick <= 1'b1;
        t_loc <= (b == 2'h0) ? t : t ^ 17'h00821;
        t_std <= (b == 2'h1) ? t : t ^ 17'h00821;
        t_utc <= (b == 2'h2) ? t : t ^ 17'h00821;
        @(posedge clock);
        sec_tick <= 1'b0;
        repeat (18) @(posedge clock);
    endtask
    task automatic burst(input int e);
        n0 = pulses;
        tick(2'h0, 17'h0);
        tick(2'h0, NB);
        chk("gated pulse count", pulses - n0, e);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock, watchdog and main sequence
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        #5_000_000;
        n_fail++;
        end_of_test;
    end
    initial begin
        {rst, reg_write, reg_read, sec_tick, low} = 5'h10;
        {reg_addr, qv, reg_wdata, t_loc, t_std, t_utc} = '0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            wr(ctp_pkg::CTRL_OFFSET, {23'h0, rows[i].ctrl});
            wr(ctp_pkg::CYCLE_OFFSET, {27'h0, rows[i].cyc});
            wr(ctp_pkg::WIDTH_OFFSET, {16'h0, rows[i].w});
            low <= rows[i].ctrl[5];
            repeat (3) @(posedge clock);
            chk("idle level", {31'h0, pulse_out}, {31'h0, rows[i].ctrl[5]});
            n0 = pulses;
            tick(rows[i].ctrl[1:0], rows[i].t);
            if (rows[i].ctrl[4]) repeat (rows[i].w * CMS + 20) @(posedge clock);
            else repeat (rows[i].w) tick(rows[i].ctrl[1:0], NB);
            chk("pulse count", pulses - n0, rows[i].n);
            if (rows[i].n > 0) chk("pulse length", last_len, rows[i].len);
        end
        rst <= 1'b1;
        low <= 1'b0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(raddr[i], d);
            chk("reset value", d, rval[i]);
        end
        wr(ctp_pkg::CTRL_OFFSET, 32'h180);
        wr(ctp_pkg::CYCLE_OFFSET, 32'h2);
        wr(ctp_pkg::WIDTH_OFFSET, 32'h1);
        burst(0);
        rd(ctp_pkg::STATUS_OFFSET, d);
        chk("reached flag", {31'h0, d[3]}, 32'h0);
        chk("config valid", {31'h0, d[6]}, 32'h1);
        for (int i = 0; i < 10; i++) begin
            qv <= qrow[i];
            repeat (4) @(posedge clock);
            rd(ctp_pkg::STATUS_OFFSET, d);
            chk("quality rank", {29'h0, d[2:0]}, {29'h0, qrank[i]});
        end
        rd(ctp_pkg::STATUS_OFFSET, d);
        chk("reached flag", {31'h0, d[3]}, 32'h1);
        burst(1);
        qv <= 8'hd0;
        burst(0);
        qv <= 8'hc0;
        burst(1);
        wr(ctp_pkg::TIMEOUT_OFFSET, 32'h1);
        qv <= 8'hd0;
        burst(1);
        repeat (60) tick(2'h0, NB);
        burst(0);
        end_of_test;
    end
endmodule

bind ctp_pulse_gen ctp_monitor u_mon (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sec_tick(sec_tick),
    .time_valid(time_valid), .time_locked(time_locked), .steering_active(steering_active),
    .loss_holdoff_timer(loss_holdoff_timer), .simulation_mode(simulation_mode),
    .acquisition_timer(acquisition_timer), .was_locked(was_locked), .set_after_reset(set_after_reset),
    .pulse_out(pulse_out));
